// ===== rtl/block_clock_gate.sv
`timescale 1ns/100ps

module block_clock_gate
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // disable request per block
    input  wire logic [WIDTH-1:0] off,
    // per-block enables
    output logic      [WIDTH-1:0] clk_en,
    output logic      [WIDTH-1:0] req_en
);

    // ----------------------------------------------------------------
    // requests drop before the clock stops, clock runs before requests
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
            clk_en <= '1;
        else
            clk_en <= ~off | req_en;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            req_en <= '1;
        else
            req_en <= ~off & clk_en;
    end

endmodule

// ===== rtl/power_down_control.sv
`timescale 1ns/100ps

module power_down_control
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // sequencer io port
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_hit,
    // pins from outside
    input  wire logic        power_down_request_n,
    input  wire logic        external_clock_strap_n,
    // same-clock status from other blocks
    input  wire logic        refresh_clock_control,
    input  wire logic        capture_enable,
    // memory requests and zoom data
    input  wire logic        lcd_write_req_in,
    input  wire logic        lcd_read_req_in,
    input  wire logic        zoom_req_in,
    input  wire logic        zoom_data_valid_in,
    output logic             lcd_write_req_out,
    output logic             lcd_read_req_out,
    output logic             zoom_req_out,
    output logic             zoom_data_valid_out,
    // power state
    output logic             standby_active,
    output logic             sleep_active,
    output logic             self_refresh_en,
    output logic             refresh_clk_en,
    // pin output enables, low while driving
    output logic             panel_serial_clock_out_oe_n,
    output logic [18:0]      video_port_out_oe_n,
    output logic             blank_tv_clock_oe_n,
    output logic [31:0]      panel_out_oe_n,
    output logic [63:0]      memory_if_oe_n,
    // block clock enables, one per disable bit
    output logic [7:0]       block_clk_en
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] index_r;
    logic [7:0] power_mode_r;
    logic [7:0] block_disable_r;
    logic       pd_meta_r;
    logic       pd_sync_r;
    logic       strap_meta_r;
    logic       strap_sync_r;
    logic       strap_taken_r;
    logic       external_clock_r;

    power_down_pkg::power_state_e state_r;
    power_down_pkg::power_state_e state_nxt;

    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic       low_power;
    logic       div_run;
    logic [4:0] div_ratio;
    logic [7:0] block_off;
    logic [7:0] block_req_en;

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    assign index_wr = io_wr && io_addr == power_down_pkg::SEQ_INDEX_PORT;
    assign data_wr  = io_wr && io_addr == power_down_pkg::SEQ_DATA_PORT;
    assign data_rd  = io_rd && io_addr == power_down_pkg::SEQ_DATA_PORT;

    always_ff @(posedge clock)
    begin
        if (srst)
            index_r <= power_down_pkg::RST_INDEX;
        else if (index_wr)
            index_r <= io_wdata;
    end

    // system clock only, so access works with synthesizers off
    always_ff @(posedge clock)
    begin
        if (srst)
            power_mode_r <= power_down_pkg::RST_POWER_MODE;
        else if (data_wr && index_r == power_down_pkg::IDX_POWER_MODE)
            power_mode_r <= io_wdata;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            block_disable_r <= power_down_pkg::RST_BLOCK_DISABLE;
        else if (data_wr && index_r == power_down_pkg::IDX_BLOCK_DISABLE)
            block_disable_r <= io_wdata;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            io_rdata     <= power_down_pkg::READ_UNMAPPED;
            io_rdata_hit <= 1'b0;
        end
        else if (data_rd)
        begin
            case (index_r)
                power_down_pkg::IDX_POWER_MODE:
                begin
                    io_rdata     <= power_mode_r;
                    io_rdata_hit <= 1'b1;
                end
                power_down_pkg::IDX_BLOCK_DISABLE:
                begin
                    io_rdata     <= block_disable_r;
                    io_rdata_hit <= 1'b1;
                end
                default:
                begin
                    io_rdata     <= power_down_pkg::READ_UNMAPPED;
                    io_rdata_hit <= 1'b0;
                end
            endcase
        end
        else
        begin
            io_rdata_hit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers and strap capture
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pd_meta_r <= 1'b1;
            pd_sync_r <= 1'b1;
        end
        else
        begin
            pd_meta_r <= power_down_request_n;
            pd_sync_r <= pd_meta_r;
        end
    end

    always_ff @(posedge clock)
    begin
        strap_meta_r <= external_clock_strap_n;
        strap_sync_r <= strap_meta_r;
    end

    // strap is caught once, on the first edge after reset release
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            strap_taken_r    <= 1'b0;
            external_clock_r <= 1'b0;
        end
        else if (!strap_taken_r)
        begin
            strap_taken_r    <= 1'b1;
            external_clock_r <= strap_sync_r;
        end
    end

    // ----------------------------------------------------------------
    // power state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = power_down_pkg::PM_NORMAL;
        case (state_r)
            power_down_pkg::PM_NORMAL,
            power_down_pkg::PM_STANDBY,
            power_down_pkg::PM_SLEEP:
            begin
                if (!pd_sync_r)
                begin
                    if (power_mode_r[power_down_pkg::MODE_SEL_BIT])
                        state_nxt = power_down_pkg::PM_SLEEP;
                    else
                        state_nxt = power_down_pkg::PM_STANDBY;
                end
            end
            default:
                state_nxt = power_down_pkg::PM_NORMAL;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            state_r <= power_down_pkg::PM_NORMAL;
        else
            state_r <= state_nxt;
    end

    assign standby_active = state_r == power_down_pkg::PM_STANDBY;
    assign sleep_active   = state_r == power_down_pkg::PM_SLEEP;
    assign low_power      = standby_active || sleep_active;

    always_ff @(posedge clock)
    begin
        if (srst)
            self_refresh_en <= 1'b0;
        else
            self_refresh_en <= state_nxt == power_down_pkg::PM_SLEEP
                && power_mode_r[power_down_pkg::REFRESH_TYPE_BIT];
    end

    // ----------------------------------------------------------------
    // refresh clock divide
    // ----------------------------------------------------------------
    always_comb
    begin
        div_ratio = power_down_pkg::RATIO_1;
        case (power_mode_r[power_down_pkg::DIV_HI_BIT:power_down_pkg::DIV_LO_BIT])
            power_down_pkg::DIV_CODE_NONE: div_ratio = power_down_pkg::RATIO_1;
            power_down_pkg::DIV_CODE_4:    div_ratio = power_down_pkg::RATIO_4;
            power_down_pkg::DIV_CODE_8:    div_ratio = power_down_pkg::RATIO_8;
            power_down_pkg::DIV_CODE_16:
                div_ratio = sleep_active ? power_down_pkg::RATIO_16
                                         : power_down_pkg::RATIO_1;
            default:                       div_ratio = power_down_pkg::RATIO_1;
        endcase
        if (!(low_power && refresh_clock_control))
            div_ratio = power_down_pkg::RATIO_1;
    end

    assign div_run = 1'b1;

    refresh_clock_divider i_refresh_clock_divider
    (
        .clock (clock),
        .srst  (srst),
        .run   (div_run),
        .ratio (div_ratio),
        .tick  (refresh_clk_en)
    );

    // ----------------------------------------------------------------
    // pin tri-state controls
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            panel_serial_clock_out_oe_n <= 1'b1;
            video_port_out_oe_n         <= '1;
            blank_tv_clock_oe_n         <= 1'b1;
            panel_out_oe_n              <= '1;
            memory_if_oe_n              <= '1;
        end
        else
        begin
            // pin is driven unless the strap says external clock or its tri-state bit is set
            panel_serial_clock_out_oe_n <= !external_clock_r
                || power_mode_r[power_down_pkg::SERCLK_TRI_BIT];
            video_port_out_oe_n <= {19{power_mode_r[power_down_pkg::VIDEO_TRI_BIT]
                || capture_enable}};
            blank_tv_clock_oe_n <= power_mode_r[power_down_pkg::VIDEO_TRI_BIT];
            panel_out_oe_n  <= {32{power_mode_r[power_down_pkg::PANEL_TRI_BIT]}};
            memory_if_oe_n  <= {64{power_mode_r[power_down_pkg::MEMORY_TRI_BIT]}};
        end
    end

    // ----------------------------------------------------------------
    // functional block gating
    // ----------------------------------------------------------------
    always_comb
    begin
        block_off = block_disable_r;
        // palette also stops in any low power state
        block_off[power_down_pkg::PALETTE_OFF_BIT] =
            block_disable_r[power_down_pkg::PALETTE_OFF_BIT] || low_power;
    end

    block_clock_gate
    #(
        .WIDTH (power_down_pkg::NUM_BLOCKS)
    )
    i_block_clock_gate
    (
        .clock  (clock),
        .srst   (srst),
        .off    (block_off),
        .clk_en (block_clk_en),
        .req_en (block_req_en)
    );

    // memory requests are withdrawn a cycle before the clock stops
    assign lcd_write_req_out   = lcd_write_req_in
        && block_req_en[power_down_pkg::LCD_WR_OFF_BIT];
    assign lcd_read_req_out    = lcd_read_req_in
        && block_req_en[power_down_pkg::LCD_RD_OFF_BIT];
    assign zoom_req_out        = zoom_req_in
        && block_req_en[power_down_pkg::ZOOM_OFF_BIT];
    assign zoom_data_valid_out = zoom_data_valid_in
        && block_req_en[power_down_pkg::ZOOM_OFF_BIT];

endmodule

// ===== rtl/power_down_pkg.sv
package power_down_pkg;

    // ----------------------------------------------------------------
    // sequencer indexed port
    // ----------------------------------------------------------------
    localparam logic [15:0] SEQ_INDEX_PORT    = 16'h03C4;
    localparam logic [15:0] SEQ_DATA_PORT     = 16'h03C5;
    localparam logic [7:0]  IDX_POWER_MODE    = 8'h20;
    localparam logic [7:0]  IDX_BLOCK_DISABLE = 8'h21;
    localparam logic [7:0]  RST_INDEX         = 8'h00;
    localparam logic [7:0]  RST_POWER_MODE    = 8'h04;
    localparam logic [7:0]  RST_BLOCK_DISABLE = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    // ----------------------------------------------------------------
    // power mode and pin tri-state fields
    // ----------------------------------------------------------------
    localparam int MODE_SEL_BIT     = 7;
    localparam int REFRESH_TYPE_BIT = 6;
    localparam int DIV_HI_BIT       = 5;
    localparam int DIV_LO_BIT       = 4;
    localparam int SERCLK_TRI_BIT   = 3;
    localparam int VIDEO_TRI_BIT    = 2;
    localparam int PANEL_TRI_BIT    = 1;
    localparam int MEMORY_TRI_BIT   = 0;

    localparam logic [1:0] DIV_CODE_NONE = 2'h0;
    localparam logic [1:0] DIV_CODE_4    = 2'h1;
    localparam logic [1:0] DIV_CODE_8    = 2'h2;
    localparam logic [1:0] DIV_CODE_16   = 2'h3;
    localparam logic [4:0] RATIO_1       = 5'h01;
    localparam logic [4:0] RATIO_4       = 5'h04;
    localparam logic [4:0] RATIO_8       = 5'h08;
    localparam logic [4:0] RATIO_16      = 5'h10;

    // ----------------------------------------------------------------
    // functional block disable fields
    // ----------------------------------------------------------------
    localparam int NUM_BLOCKS       = 8;
    localparam int DAC_OFF_BIT      = 7;
    localparam int SYNTH_OFF_BIT    = 6;
    localparam int LCD_WR_OFF_BIT   = 5;
    localparam int LCD_RD_OFF_BIT   = 4;
    localparam int PALETTE_OFF_BIT  = 3;
    localparam int ZOOM_OFF_BIT     = 2;
    localparam int DRAW_OFF_BIT     = 1;
    localparam int VPROC_OFF_BIT    = 0;

    // ----------------------------------------------------------------
    // pin groups
    // ----------------------------------------------------------------
    localparam int VIDEO_PINS  = 19;
    localparam int PANEL_PINS  = 32;
    localparam int MEMORY_PINS = 64;

    typedef enum logic [1:0]
    {
        PM_NORMAL  = 2'b00,
        PM_STANDBY = 2'b01,
        PM_SLEEP   = 2'b10
    } power_state_e;

endpackage

// ===== rtl/refresh_clock_divider.sv
`timescale 1ns/100ps

module refresh_clock_divider
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // control
    input  wire logic       run,
    input  wire logic [4:0] ratio,
    // enable pulse
    output logic            tick
);

    logic [4:0] count_r;

    // ----------------------------------------------------------------
    // counter, restarts whenever the divider is idle
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst || !run || count_r >= ratio - 5'h01)
            count_r <= 5'h00;
        else
            count_r <= count_r + 5'h01;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            tick <= 1'b0;
        else
            tick <= run && (count_r >= ratio - 5'h01);
    end

endmodule

// ===== test/power_down_control_sva.sv
`timescale 1ns/100ps

module power_down_control_sva
(
    // clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // register port
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_hit,
    // power state
    input wire logic        power_down_request_n,
    input wire logic        capture_enable,
    input wire logic        standby_active,
    input wire logic        sleep_active,
    input wire logic        self_refresh_en,
    // pin enables and block clocks
    input wire logic [18:0] video_port_out_oe_n,
    input wire logic [63:0] memory_if_oe_n,
    input wire logic [7:0]  block_clk_en
);
    logic [7:0] index_r;
    logic [7:0] mode_r;
    logic [7:0] blk_r;
    logic       at_data;
    logic       mapped;

    // ----------------------------------------------------------------
    // shadow copy of the index and both registers
    // ----------------------------------------------------------------
    assign at_data = io_addr == power_down_pkg::SEQ_DATA_PORT;
    assign mapped  = index_r == power_down_pkg::IDX_POWER_MODE
                  || index_r == power_down_pkg::IDX_BLOCK_DISABLE;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            index_r <= power_down_pkg::RST_INDEX;
            mode_r  <= power_down_pkg::RST_POWER_MODE;
            blk_r   <= power_down_pkg::RST_BLOCK_DISABLE;
        end
        else if (io_wr && io_addr == power_down_pkg::SEQ_INDEX_PORT)
            index_r <= io_wdata;
        else if (io_wr && at_data && index_r == power_down_pkg::IDX_POWER_MODE)
            mode_r <= io_wdata;
        else if (io_wr && at_data && index_r == power_down_pkg::IDX_BLOCK_DISABLE)
            blk_r <= io_wdata;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_read_data;
        io_rd && at_data && mapped |=> io_rdata_hit && io_rdata ==
            (($past(index_r) == power_down_pkg::IDX_POWER_MODE) ? $past(mode_r) : $past(blk_r));
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("register read data wrong");

    property p_unmapped;
        io_rd && at_data && !mapped |=> !io_rdata_hit && io_rdata == power_down_pkg::READ_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    property p_read_hold;
        !io_rd |=> $stable(io_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data moved without a read");

    property p_state;
        (!power_down_request_n)[*4] ##0 $stable(mode_r) |-> sleep_active == mode_r[7]
            && standby_active == !mode_r[7] && self_refresh_en == (mode_r[7] && mode_r[6]);
    endproperty
    a_state: assert property (p_state)
        else $error("low power state wrong");

    property p_wake;
        power_down_request_n[*4] |-> !sleep_active && !standby_active && !self_refresh_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("low power without request");

    property p_video_oe;
        video_port_out_oe_n == {19{$past(mode_r[2] || capture_enable || srst)}};
    endproperty
    a_video_oe: assert property (p_video_oe)
        else $error("video port enable wrong");

    property p_memory_oe;
        memory_if_oe_n == {64{$past(mode_r[0] || srst)}};
    endproperty
    a_memory_oe: assert property (p_memory_oe)
        else $error("memory pin enable wrong");

    property p_clk_gate;
        {block_clk_en[7:4], block_clk_en[2:0]} == ~({$past(blk_r[7:4]), $past(blk_r[2:0])}
            & {$past(blk_r[7:4], 2), $past(blk_r[2:0], 2)});
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("block clock enable wrong");
endmodule

// ===== test/test_power_down_control.sv
`timescale 1ns/100ps

module test_power_down_control;
    logic        clock, srst, wr, rd, pd_n, strap_n, rcc, cap, hit;
    logic        stby, slp, sref, rclk, ser_oe, blk_oe;
    logic [3:0]  req_in, req_out;
    logic [7:0]  wdata, rdata, clk_en;
    logic [15:0] addr;
    logic [18:0] vid_oe;
    logic [31:0] pan_oe;
    logic [63:0] mem_oe;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [7:0]  dmode [7] = '{8'hD0, 8'hE0, 8'hF0, 8'h30, 8'h10, 8'h10, 8'hF0};
    logic        dpin  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic        drcc  [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int          dn    [7] = '{8, 4, 2, 32, 8, 32, 32};

    power_down_control i_power_down_control
    (
        .clock(clock), .srst(srst), .io_addr(addr), .io_wr(wr), .io_rd(rd),
        .io_wdata(wdata), .io_rdata(rdata), .io_rdata_hit(hit),
        .power_down_request_n(pd_n), .external_clock_strap_n(strap_n),
        .refresh_clock_control(rcc), .capture_enable(cap),
        .lcd_write_req_in(req_in[0]), .lcd_read_req_in(req_in[1]),
        .zoom_req_in(req_in[2]), .zoom_data_valid_in(req_in[3]),
        .lcd_write_req_out(req_out[0]), .lcd_read_req_out(req_out[1]),
        .zoom_req_out(req_out[2]), .zoom_data_valid_out(req_out[3]),
        .standby_active(stby), .sleep_active(slp), .self_refresh_en(sref),
        .refresh_clk_en(rclk), .panel_serial_clock_out_oe_n(ser_oe),
        .video_port_out_oe_n(vid_oe), .blank_tv_clock_oe_n(blk_oe),
        .panel_out_oe_n(pan_oe), .memory_if_oe_n(mem_oe), .block_clk_en(clk_en)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one strobe cycle on the io port, strobes drop again after the edge
    task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
        idle(1);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        idle(1);
        wr = 1'b0;
        rd = 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
        cyc(1'b1, power_down_pkg::SEQ_INDEX_PORT, i);
        cyc(1'b1, power_down_pkg::SEQ_DATA_PORT, d);
    endtask

    task automatic rd_reg(input logic [7:0] i, input logic [7:0] e, input logic h);
        cyc(1'b1, power_down_pkg::SEQ_INDEX_PORT, i);
        cyc(1'b0, power_down_pkg::SEQ_DATA_PORT, 8'h00);
        check("read data", 64'(rdata), 64'(e));
        check("read hit", 64'(hit), 64'(h));
    endtask

    // e = serial clock, video, blank, panel, memory
    task automatic pins(input logic [4:0] e);
        idle(2);
        check("serial clock oe", 64'(ser_oe), 64'(e[4]));
        check("video oe", 64'(vid_oe), 64'({19{e[3]}}));
        check("blank oe", 64'(blk_oe), 64'(e[2]));
        check("panel oe", 64'(pan_oe), 64'({32{e[1]}}));
        check("memory oe", mem_oe, {64{e[0]}});
    endtask

    task automatic ticks(input int n);
        int c;
        c = 0;
        repeat (32)
        begin
            idle(1);
            if (rclk === 1'b1)
                c++;
        end
        check("refresh ticks", 64'(c), 64'(n));
    endtask

    task automatic do_reset();
        srst = 1'b1;
        idle(16);
        srst = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {srst, wr, rd, rcc, cap} = 5'h10;
        {pd_n, strap_n, req_in, addr, wdata} = {2'h3, 4'hF, 16'h0000, 8'h00};
        do_reset();
        rd_reg(8'h20, 8'h04, 1'b1);
        rd_reg(8'h21, 8'h00, 1'b1);
        pins(5'b01100);
        wr_reg(8'h20, 8'hA5);
        wr_reg(8'h21, 8'h5A);
        rd_reg(8'h20, 8'hA5, 1'b1);
        rd_reg(8'h21, 8'h5A, 1'b1);
        wr_reg(8'h22, 8'hFF);
        rd_reg(8'h22, 8'h00, 1'b0);
        rd_reg(8'h20, 8'hA5, 1'b1);
        wr_reg(8'h21, 8'h00);
        wr_reg(8'h20, 8'h00);
        pins(5'b00000);
        wr_reg(8'h20, 8'h0A);
        pins(5'b10010);
        wr_reg(8'h20, 8'h05);
        pins(5'b01101);
        wr_reg(8'h20, 8'h00);
        cap = 1'b1;
        pins(5'b01000);
        cap = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(8'h21, 8'h01 << i);
            idle(3);
            check("block clocks", clk_en, {56'h0, ~(8'h01 << i)});
            check("requests", req_out, {60'h0, ~{{2{i==2}}, i==4, i==5}});
        end
        req_in = 4'h0;
        idle(1);
        check("requests idle", 64'(req_out), 64'h0);
        wr_reg(8'h21, 8'h00);
        wr_reg(8'h20, 8'hC0);
        pd_n = 1'b0;
        idle(6);
        check("sleep", 64'({slp, stby, sref, clk_en[3]}), 64'h0000_0000_0000_000A);
        rd_reg(8'h20, 8'hC0, 1'b1);
        wr_reg(8'h20, 8'h80);
        idle(3);
        check("auto refresh", 64'({slp, stby, sref}), 64'h0000_0000_0000_0004);
        wr_reg(8'h20, 8'h00);
        idle(3);
        check("standby", 64'({slp, stby, sref}), 64'h0000_0000_0000_0002);
        pd_n = 1'b1;
        idle(6);
        check("normal", 64'({slp, stby, clk_en}), 64'h0000_0000_0000_00FF);
        for (int i = 0; i < 7; i++)
        begin
            wr_reg(8'h20, dmode[i]);
            pd_n = dpin[i];
            rcc = drcc[i];
            idle(12);
            ticks(dn[i]);
        end
        pd_n = 1'b1;
        strap_n = 1'b0;
        do_reset();
        rd_reg(8'h20, 8'h04, 1'b1);
        wr_reg(8'h20, 8'h00);
        pins(5'b10000);
        test_done();
    end
endmodule

bind power_down_control power_down_control_sva i_power_down_control_sva
(
    .clock(clock), .srst(srst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_hit(io_rdata_hit),
    .power_down_request_n(power_down_request_n), .capture_enable(capture_enable),
    .standby_active(standby_active), .sleep_active(sleep_active),
    .self_refresh_en(self_refresh_en), .video_port_out_oe_n(video_port_out_oe_n),
    .memory_if_oe_n(memory_if_oe_n), .block_clk_en(block_clk_en)
);
